/* File: pkg/mrw_pd_defs.vh */
// Constants for the mode register write, calibration and power-down command logic.
// Assumes inclusion by bare name from the core design file.
`ifndef MRW_PD_DEFS_VH
`define MRW_PD_DEFS_VH
`define MA_ZQ_CAL        8'h0a
`define MA_RESET         8'h3f
`define ZQ_CODE_INIT     8'hff
`define ZQ_CODE_LONG     8'hab
`define ZQ_CODE_SHORT    8'h56
`define ZQ_CODE_RESET    8'hc3
`define MR_RO_LO         8'h04
`define MR_RO_HI         8'h08
`define T_MRW_CYC        16'h0005
`define T_INIT4_CYC      16'h000a
`define T_ZQINIT_CYC     16'h0064
`define T_ZQCL_CYC       16'h003c
`define T_ZQCS_CYC       16'h0014
`define T_ZQRESET_CYC    16'h0005
`define MR_DEFAULT       8'h00
`endif

/* File: core/mrw_pd_core.v */
// Device-side decode of mode register write, reset, calibration and power-down.
// Assumes ck, cke, cs_n and ca come from pins in another domain; mclk oversamples ck.
`timescale 1ns/10ps
`include "mrw_pd_defs.vh"
module mrw_pd_core #(
  parameter MR_COUNT = 256
) (
  input  wire       mclk,
  input  wire       arst_n,
  input  wire       ck,
  input  wire       cke,
  input  wire       cs_n,
  input  wire [9:0] ca,
  input  wire       zq_tied_high,
  input  wire       bank_active,
  output reg        mrw_strobe,
  output reg  [7:0] mrw_addr,
  output reg  [7:0] mrw_data,
  output reg        mrw_refused,
  output reg        init_busy,
  output reg        zq_busy,
  output reg  [1:0] zq_kind,
  output reg        pd_active,
  output reg        pd_idle_kind,
  output reg        refresh_block
);
  // States, one-hot
  // One-hot keeps each state test a single flop in the decode
  localparam ST_IDLE = 4'b0001;
  localparam ST_MRW  = 4'b0010;
  localparam ST_WAIT = 4'b0100;
  localparam ST_PD   = 4'b1000;
  // Two-stage synchronisers for every pin
  reg [12:0] s1_reg;     // First stage, read only by stage two
  reg [12:0] s2_reg;     // Stable copies
  reg        ck_d_reg;   // Previous sampled clock level
  reg [3:0]  state_reg;  // Command state
  reg [15:0] cnt_reg;    // Busy countdown
  reg        cke_prev_reg; // CKE at previous rising edge
  reg [5:0]  ma_hi_reg;  // Rising-edge address part
  reg        cap_reg;    // Waiting for falling edge
  reg        bank_reg;   // Banks open at write decode
  reg [7:0]  mr_mem [0:MR_COUNT-1]; // Mode register storage
  integer    i;
  wire       s_ck   = s2_reg[12];
  wire       s_cke  = s2_reg[11];
  wire       s_cs_n = s2_reg[10];
  wire [9:0] s_ca   = s2_reg[9:0];
  wire       rise   = s_ck & ~ck_d_reg;
  wire       fall   = ~s_ck & ck_d_reg;
  // Write opcode seen at a rise; CKE itself is checked in the decode
  wire       mrw_cmd = !s_cs_n && (s_ca[3:0] == 4'h0);
  // MA7..6 arrive on the falling edge, MA5..0 on the rising edge
  wire [7:0] ma_full = {s_ca[1:0], ma_hi_reg};
  // Read-only range decode, used by the write path
  function is_ro;
    input [7:0] a;
    begin
      is_ro = (a >= `MR_RO_LO) && (a <= `MR_RO_HI);
    end
  endfunction
  // Calibration period for a command code; zero means not a code
  function [15:0] zq_len;
    input [7:0] d;
    begin
      if (d == `ZQ_CODE_INIT) zq_len = `T_ZQINIT_CYC;
      else if (d == `ZQ_CODE_LONG) zq_len = `T_ZQCL_CYC;
      else if (d == `ZQ_CODE_SHORT) zq_len = `T_ZQCS_CYC;
      else if (d == `ZQ_CODE_RESET) zq_len = `T_ZQRESET_CYC;
      else zq_len = 16'h0000;
    end
  endfunction
  // Synchronise the pins into mclk
  // Every pin shares one delay, so CA stays aligned with the ck edge seen
  always @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      s1_reg   <= 13'h0000;
      s2_reg   <= 13'h0400;
      ck_d_reg <= 1'b0;
    end else begin
      s1_reg   <= {ck, cke, cs_n, ca};
      s2_reg   <= s1_reg;
      ck_d_reg <= s_ck;
    end
  end
  // Command decode and sequencing
  // Edges come from oversampling: each ck phase must span two mclk periods
  always @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      state_reg     <= ST_IDLE;
      cnt_reg       <= 16'h0000;
      cke_prev_reg  <= 1'b1;
      ma_hi_reg     <= 6'h00;
      cap_reg       <= 1'b0;
      bank_reg      <= 1'b0;
      mrw_strobe    <= 1'b0;
      mrw_addr      <= 8'h00;
      mrw_data      <= 8'h00;
      mrw_refused   <= 1'b0;
      init_busy     <= 1'b0;
      zq_busy       <= 1'b0;
      zq_kind       <= 2'h0;
      pd_active     <= 1'b0;
      pd_idle_kind  <= 1'b0;
      refresh_block <= 1'b0;
      for (i = 0; i < MR_COUNT; i = i + 1)
        mr_mem[i] <= `MR_DEFAULT;
    end else begin
      mrw_strobe  <= 1'b0;
      mrw_refused <= 1'b0;
      if (rise)
        cke_prev_reg <= s_cke;
      case (state_reg)
        ST_IDLE: begin
          // CKE falling at a deselected rise enters power-down
          if (rise && !s_cke && cke_prev_reg && s_cs_n) begin
            state_reg     <= ST_PD;
            pd_active     <= 1'b1;
            pd_idle_kind  <= ~bank_active;
            refresh_block <= 1'b1;
          end else if (rise && s_cke && cke_prev_reg && mrw_cmd) begin
            // CKE high at this and the previous rise; keep the rising half
            ma_hi_reg <= s_ca[9:4];
            bank_reg  <= bank_active;
            cap_reg   <= 1'b1;
            state_reg <= ST_MRW;
          end
        end
        ST_MRW: begin
          // Second half of the command arrives on the falling edge
          if (cap_reg && fall) begin
            cap_reg  <= 1'b0;
            mrw_addr <= ma_full;
            mrw_data <= s_ca[9:2];
            if (bank_reg) begin
              // Banks open: nothing stored, no strobe; address, data and the refusal show
              mrw_refused <= 1'b1;
              state_reg   <= ST_IDLE;
            end else if (ma_full == `MA_RESET) begin
              // Reset form: every register in mr_mem back to default, no strobe
              for (i = 0; i < MR_COUNT; i = i + 1)
                mr_mem[i] <= `MR_DEFAULT;
              init_busy <= 1'b1;
              cnt_reg   <= `T_INIT4_CYC;
              state_reg <= ST_WAIT;
            end else if (ma_full == `MA_ZQ_CAL) begin
              // Pin tied high: code dropped, default impedance kept
              if (!zq_tied_high && zq_len(s_ca[9:2]) != 16'h0000) begin
                zq_busy <= 1'b1;
                zq_kind <= (s_ca[9:2] == `ZQ_CODE_INIT)  ? 2'h0 :
                           (s_ca[9:2] == `ZQ_CODE_LONG)  ? 2'h1 :
                           (s_ca[9:2] == `ZQ_CODE_SHORT) ? 2'h2 : 2'h3;
                cnt_reg <= zq_len(s_ca[9:2]);
              end else begin
                cnt_reg <= `T_MRW_CYC;
              end
              mrw_strobe <= ~zq_tied_high;
              state_reg  <= ST_WAIT;
            end else begin
              if (!is_ro(ma_full)) begin
                mr_mem[ma_full] <= s_ca[9:2];
                mrw_strobe <= 1'b1;
              end
              cnt_reg   <= `T_MRW_CYC;
              state_reg <= ST_WAIT;
            end
          end
        end
        ST_WAIT: begin
          // Counted in ck rising edges; the controller sends NOP meanwhile
          // A stopped ck stretches the period; nothing here times out
          if (rise) begin
            if (cnt_reg <= 16'h0001) begin
              init_busy <= 1'b0;
              zq_busy   <= 1'b0;
              state_reg <= ST_IDLE;
            end else begin
              cnt_reg <= cnt_reg - 16'h0001;
            end
          end
        end
        ST_PD: begin
          // Only CKE is looked at; CA and CS are don't care
          // Refresh stays blocked until exit; the controller bounds the stay
          if (rise && s_cke) begin
            state_reg     <= ST_IDLE;
            pd_active     <= 1'b0;
            refresh_block <= 1'b0;
          end
        end
        default: state_reg <= ST_IDLE;
      endcase
    end
  end
endmodule // mrw_pd_core

/* File: tb/mrw_pd_asserts.sv */
// Checker for the write, calibration and power-down decode.
// Assumes only the core's ports; bound after the module.
`timescale 1ns/10ps
`include "mrw_pd_defs.vh"
module mrw_pd_asserts (
  input wire       mclk,
  input wire       arst_n,
  input wire       cke,
  input wire       bank_active,
  input wire       zq_tied_high,
  input wire       mrw_strobe,
  input wire       mrw_refused,
  input wire [7:0] mrw_addr,
  input wire       init_busy,
  input wire       zq_busy,
  input wire       pd_active,
  input wire       pd_idle_kind,
  input wire       refresh_block
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!arst_n);
  a_one_verdict: assert property (!(mrw_strobe && mrw_refused))
    else $error("strobe with refusal");
  a_refuse_banks: assert property (mrw_refused |-> bank_active)
    else $error("refused while idle");
  a_strobe_pulse: assert property (mrw_strobe |=> !mrw_strobe)
    else $error("strobe too long");
  a_pd_refresh: assert property (refresh_block == pd_active)
    else $error("refresh block wrong");
  a_pd_quiet: assert property (pd_active && $past(pd_active) |-> !mrw_strobe)
    else $error("write in power-down");
  a_zq_tied: assert property ($rose(zq_busy) |-> !zq_tied_high)
    else $error("calibration without resistor");
  a_zq_addr: assert property ($rose(zq_busy) |-> mrw_addr == `MA_ZQ_CAL)
    else $error("calibration address wrong");
  a_init_addr: assert property ($rose(init_busy) |-> mrw_addr == `MA_RESET)
    else $error("init address wrong");
  a_pd_kind: assert property ($rose(pd_active) |-> !cke && pd_idle_kind == !bank_active)
    else $error("power-down entry wrong");
endmodule // mrw_pd_asserts
bind mrw_pd_core mrw_pd_asserts u_mrw_pd_asserts (.mclk(mclk), .arst_n(arst_n), .cke(cke),
  .bank_active(bank_active), .zq_tied_high(zq_tied_high), .mrw_strobe(mrw_strobe),
  .mrw_refused(mrw_refused), .mrw_addr(mrw_addr), .init_busy(init_busy), .zq_busy(zq_busy),
  .pd_active(pd_active), .pd_idle_kind(pd_idle_kind), .refresh_block(refresh_block));

/* File: tb/ctrl_model.sv */
// Controller model: link clock, clock enable, select and command bus.
// Assumes the bench calls its tasks one after another; a call step is 160 ns.
`timescale 1ns/10ps
module ctrl_model (
  output reg       ck,
  output reg       cke,
  output reg       cs_n,
  output reg [9:0] ca
);
  initial begin
    {ck, cke, cs_n, ca} = 13'h0f55;
  end
  // One link cycle, bus set a quarter period before each edge
  task cyc(input reg c, input reg e, input reg [9:0] r, input reg [9:0] f);
    begin
      {cs_n, cke, ca} = {c, e, r};
      #40 ck = 1'b1;
      #40 ca = f;
      #40 ck = 1'b0;
      #40;
    end
  endtask
  // Deselect; bus is don't care so it toggles every cycle
  task nop(input integer n);
    repeat (n) cyc(1'b1, cke, ~ca, ca);
  endtask
  // Write, then the quiet period; the bench also issues it with banks open
  task mrw(input reg [7:0] a, input reg [7:0] d, input integer q);
    begin
      cyc(1'b0, cke, {a[5:0], 4'h0}, {d, a[7:6]});
      nop(q);
    end
  endtask
  // Power-down entry or exit with select high, enable then held
  task pd(input reg e, input integer hold);
    begin
      cyc(1'b1, e, ~ca, ca);
      nop(hold);
    end
  endtask
endmodule // ctrl_model

/* File: tb/mrw_pd_core_tb.sv */
// Bench for the write, calibration and power-down decode.
// Assumes the core, its checker and the controller model.
`timescale 1ns/10ps
`include "mrw_pd_defs.vh"
module mrw_pd_core_tb;
  reg         mclk, arst_n, zq_tied_high, bank_active;
  wire        ck, cke, cs_n, mrw_strobe, mrw_refused, init_busy, zq_busy, pd_active;
  wire        pd_idle_kind, refresh_block;
  wire  [9:0] ca;
  wire  [7:0] mrw_addr, mrw_data;
  wire  [1:0] zq_kind;
  reg  [16:0] exp_q[$];
  reg   [7:0] a, d;
  reg   [7:0] codes [0:3];
  integer     failures, checks, cycles, i;
  ctrl_model u_ctrl_model (.ck(ck), .cke(cke), .cs_n(cs_n), .ca(ca));
  mrw_pd_core u_mrw_pd_core (.mclk(mclk), .arst_n(arst_n), .ck(ck), .cke(cke), .cs_n(cs_n),
    .ca(ca), .zq_tied_high(zq_tied_high), .bank_active(bank_active), .mrw_strobe(mrw_strobe),
    .mrw_addr(mrw_addr), .mrw_data(mrw_data), .mrw_refused(mrw_refused), .init_busy(init_busy),
    .zq_busy(zq_busy), .zq_kind(zq_kind), .pd_active(pd_active), .pd_idle_kind(pd_idle_kind),
    .refresh_block(refresh_block));
  always #5 mclk = ~mclk;
  task check(input string name, input [16:0] seen, input [16:0] exp);
    begin
      checks = checks + 1;
      if (seen !== exp) begin
        failures = failures + 1;
        $display("CHECK FAILED %0s expected %h seen %h", name, exp, seen);
      end
    end
  endtask
  task complete_run;
    begin
      $display("checks %0d failures %0d", checks, failures);
      if (failures == 0 && checks > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
    end
  endtask
  // Each strobe or refusal takes the oldest note; sampled mid-cycle, where it stands
  always @(negedge mclk) begin
    cycles = cycles + 1;
    if (cycles == 30000) begin
      failures = failures + 1;
      complete_run;
    end
    if (mrw_strobe === 1'b1 || mrw_refused === 1'b1) begin
      if (exp_q.size() == 0) check("spurious", 17'h1, 17'h0);
      else check("write", {mrw_refused, mrw_addr, mrw_data}, exp_q.pop_front());
    end
  end
  initial begin
    {mclk, arst_n, zq_tied_high, bank_active} = 4'h0;
    {failures, checks, cycles} = 0;
    {codes[0], codes[1]} = {`ZQ_CODE_INIT, `ZQ_CODE_LONG};
    {codes[2], codes[3]} = {`ZQ_CODE_SHORT, `ZQ_CODE_RESET};
    i = $urandom(93660);
    repeat (6) @(posedge mclk);
    @(negedge mclk) arst_n = 1'b1;
    u_ctrl_model.nop(2);
    for (i = 0; i < 3; i = i + 1) begin
      a = 8'h10 + $urandom % 32;
      d = $urandom;
      exp_q.push_back({1'b0, a, d});
      u_ctrl_model.mrw(a, d, `T_MRW_CYC + 1);
    end
    // Read-only target: address shows, nothing stored, no strobe
    u_ctrl_model.mrw(8'h05, 8'ha5, `T_MRW_CYC + 1);
    check("rowrite", {mrw_addr, mrw_data}, {8'h05, 8'ha5});
    // Open row: write refused, then active power-down, then idle power-down with banks closed
    @(negedge mclk) bank_active = 1'b1;
    exp_q.push_back({1'b1, 8'h11, 8'h5a});
    u_ctrl_model.mrw(8'h11, 8'h5a, `T_MRW_CYC + 1);
    for (i = 0; i < 2; i = i + 1) begin
      u_ctrl_model.pd(1'b0, 4);
      check("pd", {pd_active, pd_idle_kind, refresh_block}, {1'b1, i[0], 1'b1});
      u_ctrl_model.mrw(8'h12, 8'h34, 2);
      check("pdignore", {pd_active, mrw_addr}, {1'b1, 8'h11});
      u_ctrl_model.pd(1'b1, 4);
      check("pdexit", pd_active, 1'b0);
      @(negedge mclk) bank_active = 1'b0;
    end
    for (i = 0; i < 4; i = i + 1) begin
      exp_q.push_back({1'b0, `MA_ZQ_CAL, codes[i]});
      u_ctrl_model.mrw(`MA_ZQ_CAL, codes[i], 1);
      check("zq", {zq_busy, zq_kind}, {1'b1, i[1:0]});
      u_ctrl_model.nop(110);
      check("zqend", zq_busy, 1'b0);
    end
    @(negedge mclk) zq_tied_high = 1'b1;
    u_ctrl_model.mrw(`MA_ZQ_CAL, `ZQ_CODE_LONG, `T_MRW_CYC + 1);
    check("zqtied", zq_busy, 1'b0);
    u_ctrl_model.mrw(`MA_RESET, 8'h00, 1);
    check("init", init_busy, 1'b1);
    u_ctrl_model.nop(`T_INIT4_CYC + 2);
    check("initend", init_busy, 1'b0);
    check("queue", exp_q.size(), 17'h0);
    complete_run;
  end
endmodule // mrw_pd_core_tb
